// [core/dbeu_dbp_match.sv]
// Data breakpoint comparators, first register plus second as mask or breakpoint.
// Assumes issue is a one-cycle pulse per issued data access on the core clock.
`timescale 1ns/10ps
module dbeu_dbp_match
  import dbeu_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue,
  input wire logic [AW-1:0] addr,
  input wire logic store,
  input wire logic [AW-1:0] first,
  input wire logic [AW-1:0] second,
  input wire logic mask_mode,
  input wire logic [1:0] en_first,
  input wire logic [1:0] en_second,
  output logic hit
);
  typedef struct packed {
    logic hit;
  } dbeu_dbp_s;

  dbeu_dbp_s st;
  dbeu_dbp_s next_st;

  function automatic logic type_ok(input logic [1:0] en, input logic is_store);
    case (en)
      DBE_STORE: type_ok = is_store;
      DBE_ANY: type_ok = 1'b1;
      DBE_LOAD: type_ok = ~is_store;
      default: type_ok = 1'b0;
    endcase
  endfunction

  logic [AW-1:0] align;
  logic [AW-1:0] care;
  logic h0;
  logic h1;

  always_comb begin
    // Any byte of the access counts, so compare the word address only
    align = {{(AW-2){1'b1}}, 2'h0};
    care = mask_mode ? (align & ~second) : align;
    h0 = type_ok(en_first, store) & (((addr ^ first) & care) == '0);
    h1 = ~mask_mode & type_ok(en_second, store) & (((addr ^ second) & align) == '0);
    next_st.hit = resetn & issue & (h0 | h1);
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign hit = st.hit;
endmodule

// [core/dbeu_pkg.sv]
// Constants, register decode and encodings of the debug exception unit.
// Assumes the core presents coprocessor accesses already privilege-checked.
package dbeu_pkg;
  // Coprocessor register selection
  localparam logic [3:0] CRN_BP = 4'he;
  localparam logic [3:0] CRN_DEBUG_CTRL_STATUS_REG = 4'ha;
  localparam logic [3:0] CRM_IB0 = 4'h8;
  localparam logic [3:0] CRM_IB1 = 4'h9;
  localparam logic [3:0] CRM_DATA_BREAKPOINT_FIRST = 4'h0;
  localparam logic [3:0] CRM_DATA_BREAKPOINT_SECOND = 4'h3;
  localparam logic [3:0] CRM_DATA_BREAKPOINT_CONTROL = 4'h4;

  typedef enum logic [2:0] {
    RI_NONE, RI_DEBUG_CTRL_STATUS_REG, RI_IB0, RI_IB1, RI_DATA_BREAKPOINT_FIRST, RI_DATA_BREAKPOINT_SECOND, RI_DATA_BREAKPOINT_CONTROL
  } dbeu_reg_e;

  // Debug control/status field positions
  localparam int DEBUG_CTRL_STATUS_REG_GE = 31;
  localparam int DEBUG_CTRL_STATUS_REG_H = 30;
  localparam int DEBUG_CTRL_STATUS_REG_TF = 23;
  localparam int DEBUG_CTRL_STATUS_REG_TI = 22;
  localparam int DEBUG_CTRL_STATUS_REG_TD = 20;
  localparam int DEBUG_CTRL_STATUS_REG_SA = 5;
  localparam int DEBUG_CTRL_STATUS_REG_MOE = 4;
  localparam int DEBUG_CTRL_STATUS_REG_TBM = 1;
  localparam int DEBUG_CTRL_STATUS_REG_TBE = 0;
  localparam logic [31:0] DEBUG_CTRL_STATUS_REG_RST = 32'h00000000;
  localparam logic DEBUG_CTRL_STATUS_REG_TRST_H = 1'b0;
  localparam logic [6:0] DEBUG_CTRL_STATUS_REG_TRST_TRAPS = 7'h00;

  // Data breakpoint control positions and enable codes
  localparam int DATA_BREAKPOINT_CONTROL_MODE = 8;
  localparam int DATA_BREAKPOINT_CONTROL_E1 = 3;
  localparam int DATA_BREAKPOINT_CONTROL_E0 = 1;
  localparam logic [8:0] DATA_BREAKPOINT_CONTROL_RST = 9'h000;
  localparam logic [1:0] DBE_OFF = 2'h0;
  localparam logic [1:0] DBE_STORE = 2'h1;
  localparam logic [1:0] DBE_ANY = 2'h2;
  localparam logic [1:0] DBE_LOAD = 2'h3;
  localparam int IB_EN = 0;

  // Entry cause codes
  localparam logic [2:0] MOE_IBP = 3'h1;
  localparam logic [2:0] MOE_DBP = 3'h2;
  localparam logic [2:0] MOE_BKPT = 3'h3;
  localparam logic [2:0] MOE_EXT = 3'h4;
  localparam logic [2:0] MOE_VTRAP = 3'h5;
  localparam logic [2:0] MOE_TBF = 3'h6;

  // Status word
  localparam logic [4:0] MODE_DEBUG = 5'h15;
  localparam logic [4:0] MODE_ABORT = 5'h17;
  localparam int PSR_F = 6;

  // Vectors and link offset
  localparam logic [31:0] VEC_LOW = 32'h00000000;
  localparam logic [31:0] VEC_RELOC = 32'hffff0000;
  localparam logic [31:0] VEC_PABT = 32'h0000000c;
  localparam logic [31:0] VEC_DABT = 32'h00000010;
  localparam logic [31:0] LR_OFS = 32'h00000004;
  // Trap bit i guards the vector at this offset: reset, undef, swi, pabt, dabt, irq, fiq
  localparam logic [31:0] VTRAP_OFS [0:6] = '{32'h00, 32'h04, 32'h08, 32'h0c,
                                             32'h10, 32'h18, 32'h1c};

  // Event priorities, 1 is highest (1 is the core reset itself)
  localparam logic [3:0] PRIO_NONE = 4'h0;
  localparam logic [3:0] PRIO_VTRAP = 4'h2;
  localparam logic [3:0] PRIO_DABT_P = 4'h3;
  localparam logic [3:0] PRIO_DBP = 4'h4;
  localparam logic [3:0] PRIO_DABT_I = 4'h5;
  localparam logic [3:0] PRIO_BREAK = 4'h6;
  localparam logic [3:0] PRIO_FIQ = 4'h7;
  localparam logic [3:0] PRIO_IRQ = 4'h8;
  localparam logic [3:0] PRIO_IBP = 4'h9;
  localparam logic [3:0] PRIO_PABT = 4'ha;
  localparam logic [3:0] PRIO_SWI = 4'hb;
endpackage

// [core/dbeu_top.sv]
// Debug exception arbitration, halt and monitor entry, breakpoint registers.
// Assumes event inputs are one-cycle pulses from the core; TRST_N is asynchronous.
`timescale 1ns/10ps
module dbeu_top
  import dbeu_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic TRST_N,
  input wire logic CP_WR,
  input wire logic CP_RD,
  input wire logic CP_SEL14,
  input wire logic [3:0] CP_CRN,
  input wire logic [3:0] CP_CRM,
  input wire logic [31:0] CP_WDATA,
  output logic [31:0] CP_RDATA,
  input wire logic JTAG_DEBUG_CTRL_STATUS_REG_WR,
  input wire logic [31:0] JTAG_DEBUG_CTRL_STATUS_REG_WDATA,
  output logic [31:0] JTAG_DEBUG_CTRL_STATUS_REG_RDATA,
  input wire logic [31:0] CURRENT_STATUS_WORD_IN,
  input wire logic CURRENT_STATUS_WORD_RESTORE,
  input wire logic VEC_HIGH,
  input wire logic HALF_ISA,
  input wire logic [31:0] NEXT_PC,
  input wire logic [31:0] FAULT_PC,
  input wire logic IF_VALID,
  input wire logic [31:0] IF_ADDR,
  input wire logic DA_ISSUE,
  input wire logic [31:0] DA_ADDR,
  input wire logic DA_STORE,
  input wire logic EV_DABT_PRECISE,
  input wire logic EV_DABT_IMPRECISE,
  input wire logic EV_EXT_BREAK,
  input wire logic EV_TRACE_FULL,
  input wire logic EV_FIQ,
  input wire logic EV_IRQ,
  input wire logic EV_PABT,
  input wire logic EV_UNDEF_SWI,
  input wire logic EV_BKPT,
  output logic EXC_TAKE,
  output logic [3:0] EXC_PRIO,
  output logic DBG_ENTRY,
  output logic [31:0] DBG_VECTOR,
  output logic [31:0] DBG_LR,
  output logic [31:0] DBG_CURRENT_STATUS_WORD,
  output logic [31:0] DBG_SAVED_STATUS_WORD,
  output logic FSR_DBG_SET,
  output logic FAULT_UPDATE,
  output logic TRACE_ENABLE,
  output logic SPECIAL_DEBUG_STATE,
  output logic INSTR_MMU_BYPASS,
  output logic PID_REMAP_BYPASS
);
  typedef struct packed {
    logic [2:0] trst_sync;
    logic trst_lvl;
    logic ge;
    logic halt;
    logic [6:0] traps;
    logic sa;
    logic [2:0] moe;
    logic tbm;
    logic tbe;
    logic [31:0] ib0;
    logic [31:0] ib1;
    logic [31:0] data_breakpoint_first;
    logic [31:0] data_breakpoint_second;
    logic [8:0] data_breakpoint_control;
    logic special_debug_state;
    logic pend_ext;
    logic pend_tf;
    logic [31:0] cp_rdata;
    logic [31:0] j_rdata;
    logic exc_take;
    logic [3:0] exc_prio;
    logic dbg_entry;
    logic [31:0] vec;
    logic [31:0] lr;
    logic [31:0] current_status_word;
    logic [31:0] saved_status_word;
    logic fsr9;
    logic fault_upd;
    logic trace_en;
  } dbeu_state_s;

  dbeu_state_s st;
  dbeu_state_s next_st;
  logic dbp_hit;

  function automatic dbeu_reg_e reg_index(input logic sel14, input logic [3:0] crn,
                                          input logic [3:0] crm);
    reg_index = RI_NONE;
    if (sel14 && crn == CRN_DEBUG_CTRL_STATUS_REG) begin
      reg_index = RI_DEBUG_CTRL_STATUS_REG;
    end else if (!sel14 && crn == CRN_BP && crm == CRM_IB0) begin
      reg_index = RI_IB0;
    end else if (!sel14 && crn == CRN_BP && crm == CRM_IB1) begin
      reg_index = RI_IB1;
    end else if (!sel14 && crn == CRN_BP && crm == CRM_DATA_BREAKPOINT_FIRST) begin
      reg_index = RI_DATA_BREAKPOINT_FIRST;
    end else if (!sel14 && crn == CRN_BP && crm == CRM_DATA_BREAKPOINT_SECOND) begin
      reg_index = RI_DATA_BREAKPOINT_SECOND;
    end else if (!sel14 && crn == CRN_BP && crm == CRM_DATA_BREAKPOINT_CONTROL) begin
      reg_index = RI_DATA_BREAKPOINT_CONTROL;
    end
  endfunction

  function automatic logic [31:0] debug_ctrl_status_reg_word(input dbeu_state_s s);
    debug_ctrl_status_reg_word = {s.ge, s.halt, 6'h00, s.traps[6:5], 1'b0, s.traps[4:0], 10'h000,
                 s.sa, s.moe, s.tbm, s.tbe};
  endfunction

  // Raw register compare, bit 1 ignored for full-word code
  function automatic logic ib_hit(input logic [31:0] r, input logic [31:0] a,
                                  input logic half);
    ib_hit = r[IB_EN] && r[31:2] == a[31:2] && (!half || r[1] == a[1]);
  endfunction

  function automatic logic vtrap_hit(input logic [6:0] t, input logic [31:0] a,
                                     input logic [31:0] base);
    vtrap_hit = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (t[i] && a == base + VTRAP_OFS[i]) begin
        vtrap_hit = 1'b1;
      end
    end
  endfunction

  function automatic logic [3:0] first_prio(input logic [11:2] r);
    first_prio = PRIO_NONE;
    for (int i = 11; i >= 2; i--) begin
      if (r[i]) begin
        first_prio = 4'(i);
      end
    end
  endfunction

  dbeu_dbp_match #(
    .AW(32)
  ) u_dbp (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .issue(DA_ISSUE),
    .addr(DA_ADDR),
    .store(DA_STORE),
    .first(st.data_breakpoint_first),
    .second(st.data_breakpoint_second),
    .mask_mode(st.data_breakpoint_control[DATA_BREAKPOINT_CONTROL_MODE]),
    .en_first(st.data_breakpoint_control[DATA_BREAKPOINT_CONTROL_E0 -: 2]),
    .en_second(st.data_breakpoint_control[DATA_BREAKPOINT_CONTROL_E1 -: 2]),
    .hit(dbp_hit)
  );

  dbeu_reg_e ri;
  logic sw_ok;
  logic mode_abt;
  logic dbg_ok;
  logic [31:0] base;
  logic [6:0] tmask;
  logic vt;
  logic ext_in;
  logic tf_in;
  logic ext;
  logic tf;
  logic ibp;
  logic bkd;
  logic [11:2] req;
  logic [3:0] prio;
  logic dbgev;
  logic dcls;

  always_comb begin
    next_st = st;
    // Third flop joins the compare so a glitch never counts
    next_st.trst_sync = {st.trst_sync[1:0], TRST_N};
    if (st.trst_sync[1] == st.trst_sync[2]) begin
      next_st.trst_lvl = st.trst_sync[1];
    end
    next_st.exc_take = 1'b0;
    next_st.dbg_entry = 1'b0;
    next_st.fsr9 = 1'b0;

    ri = reg_index(CP_SEL14, CP_CRN, CP_CRM);
    sw_ok = CP_WR && (!st.halt || st.special_debug_state);
    if (sw_ok) begin
      if (ri == RI_DEBUG_CTRL_STATUS_REG) begin
        next_st.ge = CP_WDATA[DEBUG_CTRL_STATUS_REG_GE];
        next_st.sa = CP_WDATA[DEBUG_CTRL_STATUS_REG_SA];
        next_st.moe = CP_WDATA[DEBUG_CTRL_STATUS_REG_MOE -: 3];
        next_st.tbm = CP_WDATA[DEBUG_CTRL_STATUS_REG_TBM];
        next_st.tbe = CP_WDATA[DEBUG_CTRL_STATUS_REG_TBE];
      end else if (ri == RI_IB0) begin
        next_st.ib0 = CP_WDATA;
      end else if (ri == RI_IB1) begin
        next_st.ib1 = CP_WDATA;
      end else if (ri == RI_DATA_BREAKPOINT_FIRST) begin
        next_st.data_breakpoint_first = CP_WDATA;
      end else if (ri == RI_DATA_BREAKPOINT_SECOND) begin
        next_st.data_breakpoint_second = CP_WDATA;
      end else if (ri == RI_DATA_BREAKPOINT_CONTROL) begin
        next_st.data_breakpoint_control = {CP_WDATA[DATA_BREAKPOINT_CONTROL_MODE], 4'h0, CP_WDATA[DATA_BREAKPOINT_CONTROL_E1:0]};
      end
    end
    if (JTAG_DEBUG_CTRL_STATUS_REG_WR) begin
      next_st.halt = JTAG_DEBUG_CTRL_STATUS_REG_WDATA[DEBUG_CTRL_STATUS_REG_H];
      next_st.traps = {JTAG_DEBUG_CTRL_STATUS_REG_WDATA[DEBUG_CTRL_STATUS_REG_TF], JTAG_DEBUG_CTRL_STATUS_REG_WDATA[DEBUG_CTRL_STATUS_REG_TI],
                       JTAG_DEBUG_CTRL_STATUS_REG_WDATA[DEBUG_CTRL_STATUS_REG_TD -: 5]};
    end
    if (CP_RD) begin
      case (ri)
        RI_DEBUG_CTRL_STATUS_REG: next_st.cp_rdata = debug_ctrl_status_reg_word(st);
        RI_IB0: next_st.cp_rdata = st.ib0;
        RI_IB1: next_st.cp_rdata = st.ib1;
        RI_DATA_BREAKPOINT_FIRST: next_st.cp_rdata = st.data_breakpoint_first;
        RI_DATA_BREAKPOINT_SECOND: next_st.cp_rdata = st.data_breakpoint_second;
        RI_DATA_BREAKPOINT_CONTROL: next_st.cp_rdata = {23'h000000, st.data_breakpoint_control};
        default: next_st.cp_rdata = 32'h00000000;
      endcase
    end
    next_st.j_rdata = debug_ctrl_status_reg_word(st);

    mode_abt = CURRENT_STATUS_WORD_IN[4:0] == MODE_ABORT;
    dbg_ok = st.ge && !st.special_debug_state;
    base = VEC_HIGH ? VEC_RELOC : VEC_LOW;
    // Reset vector trap works even with debug globally off
    tmask = st.ge ? st.traps : {6'h00, st.traps[0]};
    vt = st.halt && !st.special_debug_state && IF_VALID && vtrap_hit(tmask, IF_ADDR, base);
    ext_in = st.ge && (EV_EXT_BREAK || st.pend_ext);
    tf_in = st.ge && (EV_TRACE_FULL || st.pend_tf);
    ext = ext_in && !mode_abt && !st.special_debug_state;
    tf = tf_in && !mode_abt && !st.special_debug_state;
    ibp = dbg_ok && IF_VALID && (ib_hit(st.ib0, IF_ADDR, HALF_ISA) ||
                                 ib_hit(st.ib1, IF_ADDR, HALF_ISA));
    bkd = dbg_ok && EV_BKPT;

    req = '0;
    req[PRIO_VTRAP] = vt;
    req[PRIO_DABT_P] = EV_DABT_PRECISE && !st.special_debug_state;
    req[PRIO_DBP] = dbp_hit && dbg_ok;
    req[PRIO_DABT_I] = EV_DABT_IMPRECISE && !st.special_debug_state;
    req[PRIO_BREAK] = ext || tf;
    req[PRIO_FIQ] = EV_FIQ && !st.special_debug_state && !CURRENT_STATUS_WORD_IN[PSR_F];
    req[PRIO_IRQ] = EV_IRQ && !st.special_debug_state && !CURRENT_STATUS_WORD_IN[PSR_F+1];
    req[PRIO_IBP] = ibp;
    req[PRIO_PABT] = EV_PABT && !st.special_debug_state;
    req[PRIO_SWI] = EV_UNDEF_SWI || bkd;
    prio = first_prio(req);
    dbgev = prio == PRIO_VTRAP || prio == PRIO_DBP || prio == PRIO_BREAK ||
            prio == PRIO_IBP || (prio == PRIO_SWI && bkd && !EV_UNDEF_SWI);
    // Data-class events report the next instruction, the rest the faulting one
    dcls = prio == PRIO_DBP || prio == PRIO_BREAK;

    next_st.pend_ext = ext_in;
    next_st.pend_tf = tf_in;
    if (prio != PRIO_NONE) begin
      next_st.exc_take = 1'b1;
      next_st.exc_prio = prio;
    end
    if (CURRENT_STATUS_WORD_RESTORE) begin
      next_st.special_debug_state = 1'b0;
    end
    if (dbgev) begin
      next_st.dbg_entry = 1'b1;
      next_st.tbe = 1'b0;
      next_st.pend_ext = 1'b0;
      next_st.pend_tf = 1'b0;
      case (prio)
        PRIO_VTRAP: next_st.moe = MOE_VTRAP;
        PRIO_DBP: next_st.moe = MOE_DBP;
        PRIO_BREAK: next_st.moe = ext ? MOE_EXT : MOE_TBF;
        PRIO_IBP: next_st.moe = MOE_IBP;
        default: next_st.moe = MOE_BKPT;
      endcase
      next_st.saved_status_word = CURRENT_STATUS_WORD_IN;
      next_st.lr = (dcls ? NEXT_PC : FAULT_PC) + LR_OFS;
      if (st.halt) begin
        next_st.vec = base;
        next_st.current_status_word = {CURRENT_STATUS_WORD_IN[31:8], 2'h3, 1'b0, MODE_DEBUG};
        next_st.special_debug_state = 1'b1;
      end else begin
        next_st.vec = dcls ? VEC_DABT : VEC_PABT;
        next_st.current_status_word = {CURRENT_STATUS_WORD_IN[31:8], 1'b1, CURRENT_STATUS_WORD_IN[PSR_F], 1'b0, MODE_ABORT};
        next_st.fsr9 = 1'b1;
      end
    end
    // Set wins over a software clear in the same cycle
    if (st.special_debug_state && (EV_DABT_PRECISE || EV_DABT_IMPRECISE)) begin
      next_st.sa = 1'b1;
    end
    next_st.fault_upd = EV_DABT_PRECISE || EV_DABT_IMPRECISE;
    next_st.trace_en = next_st.tbe && next_st.ge;

    // Core reset leaves the halt and trap bits alone
    if (!RESETN) begin
      next_st.ge = DEBUG_CTRL_STATUS_REG_RST[DEBUG_CTRL_STATUS_REG_GE];
      next_st.sa = DEBUG_CTRL_STATUS_REG_RST[DEBUG_CTRL_STATUS_REG_SA];
      next_st.moe = DEBUG_CTRL_STATUS_REG_RST[DEBUG_CTRL_STATUS_REG_MOE -: 3];
      next_st.tbm = DEBUG_CTRL_STATUS_REG_RST[DEBUG_CTRL_STATUS_REG_TBM];
      next_st.tbe = DEBUG_CTRL_STATUS_REG_RST[DEBUG_CTRL_STATUS_REG_TBE];
      next_st.ib0[IB_EN] = 1'b0;
      next_st.ib1[IB_EN] = 1'b0;
      next_st.data_breakpoint_control = DATA_BREAKPOINT_CONTROL_RST;
      next_st.special_debug_state = 1'b0;
      next_st.pend_ext = 1'b0;
      next_st.pend_tf = 1'b0;
      next_st.cp_rdata = 32'h00000000;
      next_st.j_rdata = 32'h00000000;
      next_st.exc_take = 1'b0;
      next_st.exc_prio = PRIO_NONE;
      next_st.dbg_entry = 1'b0;
      next_st.vec = 32'h00000000;
      next_st.lr = 32'h00000000;
      next_st.current_status_word = 32'h00000000;
      next_st.saved_status_word = 32'h00000000;
      next_st.fsr9 = 1'b0;
      next_st.fault_upd = 1'b0;
      next_st.trace_en = 1'b0;
    end
    if (!st.trst_lvl) begin
      next_st.halt = DEBUG_CTRL_STATUS_REG_TRST_H;
      next_st.traps = DEBUG_CTRL_STATUS_REG_TRST_TRAPS;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    st <= next_st;
  end

  assign CP_RDATA = st.cp_rdata;
  assign JTAG_DEBUG_CTRL_STATUS_REG_RDATA = st.j_rdata;
  assign EXC_TAKE = st.exc_take;
  assign EXC_PRIO = st.exc_prio;
  assign DBG_ENTRY = st.dbg_entry;
  assign DBG_VECTOR = st.vec;
  assign DBG_LR = st.lr;
  assign DBG_CURRENT_STATUS_WORD = st.current_status_word;
  assign DBG_SAVED_STATUS_WORD = st.saved_status_word;
  assign FSR_DBG_SET = st.fsr9;
  assign FAULT_UPDATE = st.fault_upd;
  assign TRACE_ENABLE = st.trace_en;
  assign SPECIAL_DEBUG_STATE = st.special_debug_state;
  assign INSTR_MMU_BYPASS = st.special_debug_state;
  assign PID_REMAP_BYPASS = st.special_debug_state;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_halt_vector: assert property (
    DBG_ENTRY && DBG_CURRENT_STATUS_WORD[4:0] == MODE_DEBUG |->
      DBG_VECTOR == ($past(VEC_HIGH) ? VEC_RELOC : VEC_LOW))
    else $error("halt entry vector wrong");
  a_halt_entry: assert property (
    DBG_ENTRY && DBG_CURRENT_STATUS_WORD[4:0] == MODE_DEBUG |-> SPECIAL_DEBUG_STATE && !TRACE_ENABLE)
    else $error("halt entry missed state or trace");
  a_halt_status: assert property (
    DBG_ENTRY && DBG_CURRENT_STATUS_WORD[4:0] == MODE_DEBUG |->
      DBG_CURRENT_STATUS_WORD[7:5] == 3'h6 && DBG_SAVED_STATUS_WORD == $past(CURRENT_STATUS_WORD_IN))
    else $error("halt status word wrong");
  a_sds_masks: assert property (
    SPECIAL_DEBUG_STATE |=> !(EXC_TAKE && (EXC_PRIO == PRIO_FIQ ||
      EXC_PRIO == PRIO_IRQ || EXC_PRIO == PRIO_PABT)))
    else $error("event taken in special state");
  a_sticky_abort: assert property (
    SPECIAL_DEBUG_STATE && EV_DABT_PRECISE |=> st.sa && FAULT_UPDATE &&
      !(EXC_TAKE && EXC_PRIO == PRIO_DABT_P))
    else $error("special state abort mishandled");
  a_sw_block: assert property (
    CP_WR && st.halt && !st.special_debug_state && ri == RI_DEBUG_CTRL_STATUS_REG |=> st.ge == $past(st.ge))
    else $error("blocked write took effect");
  a_sds_hold: assert property (
    SPECIAL_DEBUG_STATE && !CURRENT_STATUS_WORD_RESTORE |=> SPECIAL_DEBUG_STATE)
    else $error("special state left without restore");
  a_mon_entry: assert property (
    DBG_ENTRY && DBG_CURRENT_STATUS_WORD[4:0] == MODE_ABORT |-> FSR_DBG_SET && DBG_CURRENT_STATUS_WORD[7] &&
      !DBG_CURRENT_STATUS_WORD[5] && DBG_CURRENT_STATUS_WORD[6] == $past(CURRENT_STATUS_WORD_IN[6]) && !SPECIAL_DEBUG_STATE)
    else $error("monitor entry wrong");
  a_mon_link: assert property (
    DBG_ENTRY && DBG_VECTOR == VEC_DABT && DBG_CURRENT_STATUS_WORD[4:0] == MODE_ABORT |->
      DBG_LR == $past(NEXT_PC) + LR_OFS)
    else $error("monitor data link wrong");
  a_mon_vtrap: assert property (
    !st.halt ##1 DBG_ENTRY |-> st.moe != MOE_VTRAP)
    else $error("vector trap in monitor mode");

  c_halt_entry: cover property (DBG_ENTRY && SPECIAL_DEBUG_STATE);
  c_mon_entry: cover property (DBG_ENTRY && FSR_DBG_SET);
  c_sticky: cover property (SPECIAL_DEBUG_STATE && EV_DABT_PRECISE);
  c_sds_exit: cover property (SPECIAL_DEBUG_STATE ##1 !SPECIAL_DEBUG_STATE);
endmodule

// [dv/dbeu_dbg_model.sv]
// Debugger stand-in: scanned control word and tap reset.
// Assumes its tasks are entered just after a rising edge of clk.
`timescale 1ns/10ps
module dbeu_dbg_model (
  input wire logic clk,
  output logic trst_n,
  output logic debug_ctrl_status_reg_wr,
  output logic [31:0] debug_ctrl_status_reg_wdata
);
  // Power-up tap reset, else halt and trap bits stay unknown
  initial begin
    trst_n = 1'b0;
    debug_ctrl_status_reg_wr = 1'b0;
    debug_ctrl_status_reg_wdata = 32'h0;
    repeat (6) @(posedge clk);
    #1 trst_n = 1'b1;
  end
  task automatic scan(input logic [31:0] v);
    debug_ctrl_status_reg_wdata = v;
    debug_ctrl_status_reg_wr = 1'b1;
    @(posedge clk);
    #1 debug_ctrl_status_reg_wr = 1'b0;
    // Chain content is stale after the update
    debug_ctrl_status_reg_wdata = ~v;
  endtask
  task automatic tap_reset();
    trst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 trst_n = 1'b1;
  endtask
endmodule

// [dv/dbeu_top_tb.sv]
// Self-checking bench: priority, monitor and halt entry, breakpoints.
// Assumes the debugger model gives the power-up tap reset.
`timescale 1ns/10ps
module dbeu_top_tb;
  import dbeu_pkg::*;
  logic clk, rstn, wr, rd, s14, vh, iv, dv, st, trst, jwr, h;
  logic [3:0] crn, crm, pr;
  logic [9:0] ev;
  logic [31:0] wd, rdat, jwd, jrd, current_status_word, pc_n, pc_f, ad, vec, lr, ps, sp, a, b;
  logic tk, en, fs, fu, te, special_debug_state, mb, pb, hi;
  logic [31:0] r = 32'h4d26;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  dbeu_dbg_model dbg (.clk(clk), .trst_n(trst), .debug_ctrl_status_reg_wr(jwr), .debug_ctrl_status_reg_wdata(jwd));
  dbeu_top DUT (
    .CORE_CLK(clk), .RESETN(rstn), .TRST_N(trst), .CP_WR(wr), .CP_RD(rd),
    .CP_SEL14(s14), .CP_CRN(crn), .CP_CRM(crm), .CP_WDATA(wd), .CP_RDATA(rdat),
    .JTAG_DEBUG_CTRL_STATUS_REG_WR(jwr), .JTAG_DEBUG_CTRL_STATUS_REG_WDATA(jwd), .JTAG_DEBUG_CTRL_STATUS_REG_RDATA(jrd),
    .CURRENT_STATUS_WORD_IN(current_status_word), .CURRENT_STATUS_WORD_RESTORE(ev[9]), .VEC_HIGH(vh), .HALF_ISA(hi),
    .NEXT_PC(pc_n), .FAULT_PC(pc_f), .IF_VALID(iv), .IF_ADDR(ad), .DA_ISSUE(dv),
    .DA_ADDR(ad), .DA_STORE(st), .EV_DABT_PRECISE(ev[0]), .EV_DABT_IMPRECISE(ev[1]),
    .EV_EXT_BREAK(ev[2]), .EV_TRACE_FULL(ev[3]), .EV_FIQ(ev[4]), .EV_IRQ(ev[5]),
    .EV_PABT(ev[6]), .EV_UNDEF_SWI(ev[7]), .EV_BKPT(ev[8]), .EXC_TAKE(tk),
    .EXC_PRIO(pr), .DBG_ENTRY(en), .DBG_VECTOR(vec), .DBG_LR(lr), .DBG_CURRENT_STATUS_WORD(ps),
    .DBG_SAVED_STATUS_WORD(sp), .FSR_DBG_SET(fs), .FAULT_UPDATE(fu), .TRACE_ENABLE(te),
    .SPECIAL_DEBUG_STATE(special_debug_state), .INSTR_MMU_BYPASS(mb), .PID_REMAP_BYPASS(pb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] exp_prio(input logic [8:0] e);
    return e[0] ? 4'h3 : e[1] ? 4'h5 : |e[3:2] ? 4'h6 : e[4] ? 4'h7 :
      e[5] ? 4'h8 : e[6] ? 4'ha : |e[8:7] ? 4'hb : 4'h0;
  endfunction
  function automatic logic [31:0] exp_psr(input logic [31:0] x, input logic hm);
    return {x[31:8], 1'b1, hm | x[6], 1'b0, hm ? 5'h15 : 5'h17};
  endfunction
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input logic [9:0] e, input logic fi, input logic di,
                    input logic [31:0] x, input logic t);
    // Idle edge first, so pulses of back-to-back calls never merge
    settle(1);
    ev = e;
    iv = fi;
    dv = di;
    ad = x;
    st = t;
    settle(1);
    ev = 10'h0;
    iv = 1'b0;
    dv = 1'b0;
  endtask
  // Bounded wait; a take anywhere in the window counts
  task automatic take(input logic et, input logic [3:0] ep);
    for (int k = 0; k < 3 && tk !== 1'b1; k++) settle(1);
    chk("take", 32'(et), 32'(tk));
    if (et) chk("prio", 32'(ep), 32'(pr));
  endtask
  task automatic entry(input logic [31:0] v, input logic [31:0] l, input logic hm);
    chk("entry", 32'h1, 32'(en));
    chk("vector", v, vec);
    chk("link", l, lr);
    chk("current_status_word", exp_psr(current_status_word, hm), ps);
    chk("saved_status_word", current_status_word, sp);
    chk("fsr9", 32'(!hm), 32'(fs));
  endtask
  task automatic cp(input logic w, input logic s, input logic [3:0] m, input logic [31:0] x);
    s14 = s;
    crn = s ? CRN_DEBUG_CTRL_STATUS_REG : CRN_BP;
    crm = m;
    wd = x;
    wr = w;
    rd = !w;
    settle(1);
    wr = 1'b0;
    rd = 1'b0;
    settle(1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    {rstn, wr, rd, s14, vh, iv, dv, st, hi, crn, crm, ev, wd, ad} = '0;
    current_status_word = 32'h13;
    pc_n = lfsr(r);
    pc_f = lfsr(pc_n);
    settle(4);
    rstn = 1'b1;
    settle(6);
    go(10'h10c, 0, 0, 0, 0);
    take(0, 0);
    cp(1, 1, 4'h0, 32'h80000001);
    chk("trace", 32'h1, 32'(te));
    for (i = 0; i < 24; i++) begin
      r = lfsr(r);
      // First pass: every ordinary event at once
      a = (i == 0) ? 32'h1f3 : {23'h0, r[8:0] & 9'h1f3};
      go(a[9:0], 0, 0, 0, 0);
      take(|a, exp_prio(a[8:0]));
    end
    a = {r[31:2], 2'b00};
    cp(1, 0, CRM_IB0, a | 32'h1);
    cp(0, 0, CRM_IB0, 32'h0);
    chk("ib0", a | 32'h1, rdat);
    current_status_word = current_status_word | 32'h40;
    hi = 1'b1;
    go(0, 1, 0, a | 32'h2, 0);
    take(0, 0);
    go(0, 1, 0, a, 0);
    take(1, 4'h9);
    entry(32'hc, pc_f + 32'h4, 0);
    settle(2);
    chk("moe", 32'h1, 32'(jrd[4:2]));
    cp(1, 0, CRM_IB0, a);
    cp(1, 0, CRM_DATA_BREAKPOINT_FIRST, a);
    for (i = 0; i < 8; i++) begin
      cp(1, 0, CRM_DATA_BREAKPOINT_CONTROL, 32'(i / 2));
      h = (i == 3) || i / 2 == 2 || i == 6;
      go(0, 0, 1, a | 32'(i % 4), i[0]);
      take(h, 4'h4);
      if (h) entry(32'h10, pc_n + 32'h4, 0);
      // Control word image trails the state by one cycle
      if (h) settle(1);
      if (h) chk("moe", 32'h2, 32'(jrd[4:2]));
    end
    cp(1, 0, CRM_DATA_BREAKPOINT_SECOND, 32'hf0);
    cp(1, 0, CRM_DATA_BREAKPOINT_CONTROL, 32'h102);
    go(0, 0, 1, a ^ 32'h30, 1);
    take(1, 4'h4);
    go(0, 0, 1, a ^ 32'h100, 1);
    take(0, 0);
    b = a ^ 32'h1000;
    cp(1, 0, CRM_DATA_BREAKPOINT_SECOND, b);
    cp(1, 0, CRM_DATA_BREAKPOINT_CONTROL, 32'h8);
    go(0, 0, 1, b, 0);
    take(1, 4'h4);
    // External break in abort mode waits until the mode is left
    current_status_word[4:0] = 5'h17;
    go(10'h004, 0, 0, 0, 0);
    take(0, 0);
    current_status_word[4:0] = 5'h13;
    take(1, 4'h6);
    entry(32'h10, pc_n + 32'h4, 0);
    settle(2);
    chk("moe", 32'h4, 32'(jrd[4:2]));
    take(0, 0);
    dbg.scan(32'h00020000);
    settle(6);
    go(0, 1, 0, 32'h4, 0);
    take(0, 0);
    dbg.scan(32'h40000000);
    settle(2);
    cp(1, 0, CRM_IB1, b | 32'h1);
    go(0, 1, 0, b, 0);
    take(0, 0);
    vh = 1'b1;
    go(10'h100, 0, 0, 0, 0);
    take(1, 4'hb);
    entry(32'hffff0000, pc_f + 32'h4, 1);
    settle(2);
    chk("moe", 32'h3, 32'(jrd[4:2]));
    chk("trace", 32'h0, 32'(te));
    chk("state", 32'h7, {29'h0, special_debug_state, mb, pb});
    go(10'h070, 0, 0, 0, 0);
    take(0, 0);
    go(10'h001, 0, 0, 0, 0);
    chk("fault", 32'h1, 32'(fu));
    take(0, 0);
    chk("sticky", 32'h1, 32'(jrd[5]));
    cp(1, 0, CRM_IB1, b | 32'h1);
    cp(0, 0, CRM_IB1, 32'h0);
    chk("ib1", b | 32'h1, rdat);
    current_status_word[4:0] = 5'h1f;
    settle(1);
    chk("sds", 32'h1, 32'(special_debug_state));
    go(10'h200, 0, 0, 0, 0);
    chk("sds", 32'h0, 32'(special_debug_state));
    vh = 1'b0;
    go(0, 1, 0, b, 0);
    take(1, 4'h9);
    entry(32'h0, pc_f + 32'h4, 1);
    go(10'h200, 0, 0, 0, 0);
    rstn = 1'b0;
    settle(1);
    rstn = 1'b1;
    settle(2);
    chk("halt", 32'h1, {30'h0, jrd[31:30]});
    dbg.tap_reset();
    settle(6);
    chk("halt", 32'h0, 32'(jrd[30]));
    wrap_up();
  end
endmodule
